// [pkg/lfsrbm_pkg.sv]
// Package of constants and types for the LFSR parity and bit manipulation unit.
package lfsrbm_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int DATA_W = 32;   // Data register width.
   localparam int ACC_W  = 40;   // Accumulator width.
   localparam int IDX_W  = 5;    // Bit index immediate width.
   localparam int HALF_W = 16;   // Destination low half width.
   localparam int ADDR_W = 8;    // APB address width.

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_STATE_LO = 8'h00;  // State accumulator bits 31:0.
   localparam logic [7:0] OFS_STATE_HI = 8'h04;  // State accumulator bits 39:32.
   localparam logic [7:0] OFS_MASK_LO  = 8'h08;  // Mask accumulator bits 31:0.
   localparam logic [7:0] OFS_MASK_HI  = 8'h0C;  // Mask accumulator bits 39:32.
   localparam logic [7:0] OFS_DATA     = 8'h10;  // Data register operand.
   localparam logic [7:0] OFS_DEST     = 8'h14;  // Destination register.
   localparam logic [7:0] OFS_CMD      = 8'h18;  // Command, a write executes it.
   localparam logic [7:0] OFS_FLAGS    = 8'h1C;  // Status flags.

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CMD_OP_POS     = 0;   // Operation code, three bits.
   localparam int CMD_IDX_POS    = 4;   // Bit index immediate, five bits.
   localparam int CMD_PAIRED_POS = 12;  // Issued inside a parallel group.
   localparam int FLAGS_W        = 5;   // Flag bits 0..4: cond, zero, neg, carry, ovf.

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [39:0] RST_ACC  = 40'h00_0000_0000;
   localparam logic [31:0] RST_DATA = 32'h0000_0000;
   localparam logic [31:0] RST_ERR  = 32'h0000_0000;

   // ****************************************
   // Types
   // ****************************************
   // Operations, encoded in declaration order.
   typedef enum logic [2:0] {
      OP_NOP, OP_PAR_SHIFT_D, OP_PAR_D, OP_PAR_FB, OP_PAR_SHIFT_FB,
      OP_BIT_CLR, OP_BIT_SET, OP_BIT_TGL
   } lfsrbm_op_type;

   // Register selected by the address decoder.
   typedef enum logic [3:0] {
      SEL_NONE, SEL_STATE_LO, SEL_STATE_HI, SEL_MASK_LO, SEL_MASK_HI,
      SEL_DATA, SEL_DEST, SEL_CMD, SEL_FLAGS
   } lfsrbm_sel_type;

   // Command as held after a write.
   typedef struct packed {
      logic          paired;
      logic [4:0]    index;
      lfsrbm_op_type op;
   } lfsrbm_cmd_type;

   // Status flags, condition flag in bit 0.
   typedef struct packed {
      logic ovf_flag;
      logic carry_flag;
      logic negative_flag;
      logic zero_flag;
      logic condition_flag;
   } lfsrbm_flags_type;

endpackage

// [core/lfsrbm_core.sv]
// Parity (LFSR) and single-bit datapath with an APB register slave.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module lfsrbm_core
   import lfsrbm_pkg::*;
#(
   parameter int DW = lfsrbm_pkg::DATA_W,   // Data register width.
   parameter int AW = lfsrbm_pkg::ACC_W     // Accumulator width.
)
(
   // Clock and reset.
   input  wire logic                         SYS_CLK_I,
   input  wire logic                         SRST_I,
   // APB slave.
   input  wire logic                         PSEL_I,
   input  wire logic                         PENABLE_I,
   input  wire logic                         PWRITE_I,
   input  wire logic [lfsrbm_pkg::ADDR_W-1:0] PADDR_I,
   input  wire logic [31:0]                  PWDATA_I,
   output logic      [31:0]                  PRDATA_O,
   output logic                              PREADY_O,
   output logic                              PSLVERR_O,
   // Status.
   output logic                              COND_FLAG_O
);
   import lfsrbm_pkg::*;

   // ****************************************
   // Elaboration checks
   // ****************************************
   // The register map holds the high accumulator part in one word.
   if (DW != 32 || AW <= DW || AW > 2 * DW)
   begin : g_bad_width
      $error("lfsrbm_core: unsupported widths");
   end

   // ****************************************
   // Declarations
   // ****************************************
   logic [AW-1:0]      state_reg, state_next;     // State accumulator.
   logic [AW-1:0]      mask_reg, mask_next;       // Mask accumulator.
   logic [DW-1:0]      data_reg, data_next;       // Data register operand.
   logic [DW-1:0]      dest_reg, dest_next;       // Destination register.
   lfsrbm_cmd_type     cmd_reg, cmd_next;         // Last executed command.
   lfsrbm_flags_type   flags_reg, flags_next;     // Status flags.
   logic [31:0]        rdata_reg, rdata_next;     // Read data for the access phase.
   logic               err_reg, err_next;         // Error for the access phase.
   lfsrbm_sel_type     sel;                       // Decoded register.
   lfsrbm_cmd_type     cmd_w;                     // Command on the write bus.
   logic               refuse;                    // Command may not execute.
   logic               access_wr;                 // Write access phase.
   logic               exec;                      // Command executes this edge.
   logic [AW-1:0]      shifted;                   // State shifted left by one.
   logic [AW-1:0]      data_ext;                  // Data register widened.
   logic               par_shift_d;               // Shifted no-feedback result.
   logic               par_d;                     // Plain no-feedback result.
   logic               par_fb;                    // Feedback result incl. flag.
   logic [DW-1:0]      bit_mask;                  // One-hot of the bit index.
   logic [DW-1:0]      bit_res;                   // Single-bit operation result.

   // ****************************************
   // Functions
   // ****************************************
   // XOR fold from bit zero upward; one output bit.
   function automatic logic xor_fold(input logic [AW-1:0] v);
      logic acc;
      acc = 1'b0;
      for (int i = 0; i < AW; i++)
      begin
         acc = acc ^ v[i];
      end
      return acc;
   endfunction

   // Address to register select; anything else is unmapped.
   function automatic lfsrbm_sel_type addr_decode(input logic [ADDR_W-1:0] a);
      lfsrbm_sel_type s;
      s = SEL_NONE;
      if (a == OFS_STATE_LO)
         s = SEL_STATE_LO;
      else if (a == OFS_STATE_HI)
         s = SEL_STATE_HI;
      else if (a == OFS_MASK_LO)
         s = SEL_MASK_LO;
      else if (a == OFS_MASK_HI)
         s = SEL_MASK_HI;
      else if (a == OFS_DATA)
         s = SEL_DATA;
      else if (a == OFS_DEST)
         s = SEL_DEST;
      else if (a == OFS_CMD)
         s = SEL_CMD;
      else if (a == OFS_FLAGS)
         s = SEL_FLAGS;
      return s;
   endfunction

   // ****************************************
   // Bus decode
   // ****************************************
   // Zero wait states: every access completes in its first access cycle.
   assign PREADY_O  = 1'b1;
   assign PRDATA_O  = rdata_reg;
   assign PSLVERR_O = err_reg;
   assign COND_FLAG_O = flags_reg.condition_flag;

   assign sel        = addr_decode(PADDR_I);
   assign cmd_w.op   = lfsrbm_op_type'(PWDATA_I[CMD_OP_POS +: 3]);
   assign cmd_w.index  = PWDATA_I[CMD_IDX_POS +: IDX_W];
   assign cmd_w.paired = PWDATA_I[CMD_PAIRED_POS];
   // Parity operations may sit in a parallel group; bit operations may not.
   assign refuse    = cmd_w.paired &&
                      (cmd_w.op == OP_BIT_CLR || cmd_w.op == OP_BIT_SET ||
                       cmd_w.op == OP_BIT_TGL);
   assign access_wr = PSEL_I && PENABLE_I && PWRITE_I;
   assign exec      = access_wr && sel == SEL_CMD && !refuse;

   // ****************************************
   // Datapath
   // ****************************************
   // All three parity results are formed in parallel; the command picks one.
   assign shifted  = {state_reg[AW-2:0], 1'b0};
   assign data_ext = {{(AW - DW){1'b0}}, data_reg};
   assign par_shift_d = xor_fold(shifted & data_ext);
   assign par_d       = xor_fold(state_reg & data_ext);
   assign par_fb      = xor_fold(state_reg & mask_reg) ^ flags_reg.condition_flag;
   // Index 0 selects the least significant bit.
   assign bit_mask = DW'(1) << cmd_w.index;

   // Single-bit result for the three bit operations.
   always_comb
   begin
      case (cmd_w.op)
         OP_BIT_CLR: bit_res = data_reg & ~bit_mask;
         OP_BIT_SET: bit_res = data_reg | bit_mask;
         OP_BIT_TGL: bit_res = data_reg ^ bit_mask;
         default:    bit_res = data_reg;
      endcase
   end

   // ****************************************
   // Next state
   // ****************************************
   // Register writes and command execution never share an access,
   // so a single chain covers both without priority questions.
   always_comb
   begin
      state_next = state_reg;
      mask_next  = mask_reg;
      data_next  = data_reg;
      dest_next  = dest_reg;
      cmd_next   = cmd_reg;
      flags_next = flags_reg;
      if (exec)
      begin
         cmd_next = cmd_w;
         case (cmd_w.op)
            OP_PAR_SHIFT_D:
            begin
               state_next = shifted;
               dest_next[HALF_W-1:0] = {{(HALF_W - 1){1'b0}}, par_shift_d};
               flags_next.condition_flag = par_shift_d;
            end
            OP_PAR_D:
            begin
               dest_next[HALF_W-1:0] = {{(HALF_W - 1){1'b0}}, par_d};
               flags_next.condition_flag = par_d;
            end
            OP_PAR_FB:
            begin
               dest_next[HALF_W-1:0] = {{(HALF_W - 1){1'b0}}, par_fb};
               flags_next.condition_flag = par_fb;
            end
            OP_PAR_SHIFT_FB:
            begin
               // No flag is touched here, only the state moves.
               state_next = {state_reg[AW-2:0], par_fb};
            end
            OP_BIT_CLR, OP_BIT_TGL:
            begin
               data_next = bit_res;
               flags_next.zero_flag = (bit_res == '0);
               flags_next.negative_flag = bit_res[DW-1];
               flags_next.carry_flag = 1'b0;
               flags_next.ovf_flag = 1'b0;
            end
            OP_BIT_SET:
            begin
               data_next = bit_res;
               flags_next.zero_flag = 1'b0;
               flags_next.negative_flag = bit_res[DW-1];
               flags_next.carry_flag = 1'b0;
               flags_next.ovf_flag = 1'b0;
            end
            default:
            begin
               cmd_next = cmd_w;
            end
         endcase
      end
      else if (access_wr)
      begin
         // Plain register writes from software.
         if (sel == SEL_STATE_LO)
            state_next[DW-1:0] = PWDATA_I;
         else if (sel == SEL_STATE_HI)
            state_next[AW-1:DW] = PWDATA_I[AW-DW-1:0];
         else if (sel == SEL_MASK_LO)
            mask_next[DW-1:0] = PWDATA_I;
         else if (sel == SEL_MASK_HI)
            mask_next[AW-1:DW] = PWDATA_I[AW-DW-1:0];
         else if (sel == SEL_DATA)
            data_next = PWDATA_I;
         else if (sel == SEL_DEST)
            dest_next = PWDATA_I;
         else if (sel == SEL_FLAGS)
            flags_next = lfsrbm_flags_type'(PWDATA_I[FLAGS_W-1:0]);
      end
   end

   // Read data and error are captured in the setup cycle.
   always_comb
   begin
      rdata_next = RST_ERR;
      err_next   = 1'b0;
      if (sel == SEL_STATE_LO)
         rdata_next = state_reg[DW-1:0];
      else if (sel == SEL_STATE_HI)
         rdata_next = {{(2 * DW - AW){1'b0}}, state_reg[AW-1:DW]};
      else if (sel == SEL_MASK_LO)
         rdata_next = mask_reg[DW-1:0];
      else if (sel == SEL_MASK_HI)
         rdata_next = {{(2 * DW - AW){1'b0}}, mask_reg[AW-1:DW]};
      else if (sel == SEL_DATA)
         rdata_next = data_reg;
      else if (sel == SEL_DEST)
         rdata_next = dest_reg;
      else if (sel == SEL_CMD)
      begin
         rdata_next = 32'(cmd_reg.op) | (32'(cmd_reg.index) << CMD_IDX_POS)
                      | (32'(cmd_reg.paired) << CMD_PAIRED_POS);
         err_next   = PWRITE_I && refuse;
      end
      else if (sel == SEL_FLAGS)
         rdata_next = {{(32 - FLAGS_W){1'b0}}, flags_reg};
      else
         err_next = 1'b1;
   end

   // ****************************************
   // Registers
   // ****************************************
   // Accumulators.
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
      begin
         state_reg <= AW'(RST_ACC);
         mask_reg  <= AW'(RST_ACC);
      end
      else
      begin
         state_reg <= state_next;
         mask_reg  <= mask_next;
      end
   end

   // Data and destination registers.
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
      begin
         data_reg <= RST_DATA;
         dest_reg <= RST_DATA;
      end
      else
      begin
         data_reg <= data_next;
         dest_reg <= dest_next;
      end
   end

   // Command and flags.
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
      begin
         cmd_reg   <= '0;
         flags_reg <= '0;
      end
      else
      begin
         cmd_reg   <= cmd_next;
         flags_reg <= flags_next;
      end
   end

   // Bus answer, loaded only in setup cycles so it holds through access.
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SRST_I)
      begin
         rdata_reg <= RST_ERR;
         err_reg   <= 1'b0;
      end
      else if (PSEL_I && !PENABLE_I)
      begin
         rdata_reg <= rdata_next;
         err_reg   <= err_next;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (SRST_I);

   property p_nofb_flag;
      exec && cmd_w.op == OP_PAR_D |=> dest_reg[0] == flags_reg.condition_flag
         && state_reg == $past(state_reg);
   endproperty
   a_nofb_flag: assert property (p_nofb_flag) else $error("plain parity flag");

   property p_upper_zero;
      exec && (cmd_w.op == OP_PAR_D || cmd_w.op == OP_PAR_FB) |=> dest_reg[15:1] == '0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper half not zero");

   property p_shift_wb;
      exec && cmd_w.op == OP_PAR_SHIFT_D |=> state_reg == ($past(state_reg) << 1)
         && $stable(flags_reg.zero_flag) && $stable(flags_reg.carry_flag);
   endproperty
   a_shift_wb: assert property (p_shift_wb) else $error("shift write-back");

   property p_fb_shift;
      exec && cmd_w.op == OP_PAR_SHIFT_FB |=> state_reg[AW-1:1] == $past(shifted[AW-1:1])
         && $stable(flags_reg) && $stable(dest_reg);
   endproperty
   a_fb_shift: assert property (p_fb_shift) else $error("feedback shift");

   property p_fb_zero_mask;
      exec && cmd_w.op == OP_PAR_FB && (state_reg & mask_reg) == '0
         |=> flags_reg.condition_flag == $past(flags_reg.condition_flag) ##1 1'b1;
   endproperty
   a_fb_zero_mask: assert property (p_fb_zero_mask) else $error("feedback xor");

   property p_bit_clr;
      exec && cmd_w.op == OP_BIT_CLR |=> data_reg[cmd_reg.index] == 1'b0
         && ((data_reg ^ $past(data_reg)) & ~(DW'(1) << cmd_reg.index)) == '0;
   endproperty
   a_bit_clr: assert property (p_bit_clr) else $error("bit clear");

   property p_bit_set;
      exec && cmd_w.op == OP_BIT_SET |=> data_reg[cmd_reg.index] && !flags_reg.zero_flag
         && flags_reg.negative_flag == data_reg[DW-1];
   endproperty
   a_bit_set: assert property (p_bit_set) else $error("bit set");

   property p_bit_tgl;
      exec && cmd_w.op == OP_BIT_TGL |=> (data_reg ^ $past(data_reg)) == (DW'(1) << cmd_reg.index);
   endproperty
   a_bit_tgl: assert property (p_bit_tgl) else $error("bit toggle");

   property p_bit_flags;
      exec && (cmd_w.op == OP_BIT_CLR || cmd_w.op == OP_BIT_TGL) |=>
         flags_reg.zero_flag == (data_reg == '0) && flags_reg.negative_flag == data_reg[DW-1]
         && !flags_reg.carry_flag && !flags_reg.ovf_flag;
   endproperty
   a_bit_flags: assert property (p_bit_flags) else $error("bit op flags");

   property p_refused;
      access_wr && sel == SEL_CMD && refuse |=> $stable(data_reg) && $stable(flags_reg);
   endproperty
   a_refused: assert property (p_refused) else $error("paired bit op ran");

endmodule

`default_nettype wire

// [dv/lfsrbm_apb_master.sv]
// APB master model that stands in for the instruction decoder and register file.
`timescale 1ns/1ps
`default_nettype none

module lfsrbm_apb_master
   import lfsrbm_pkg::*;
(
   // Clock.
   input  wire logic                          SYS_CLK_I,
   // APB request.
   output logic                               PSEL_O,
   output logic                               PENABLE_O,
   output logic                               PWRITE_O,
   output logic [lfsrbm_pkg::ADDR_W-1:0]      PADDR_O,
   output logic [31:0]                        PWDATA_O,
   // APB answer.
   input  wire logic [31:0]                   PRDATA_I,
   input  wire logic                          PREADY_I,
   input  wire logic                          PSLVERR_I
);
   // ****************************************
   // Idle levels
   // ****************************************
   // The bus starts idle so the slave sees no request during reset.
   initial
   begin
      PSEL_O    = 1'b0;
      PENABLE_O = 1'b0;
      PWRITE_O  = 1'b0;
      PADDR_O   = 8'h00;
      PWDATA_O  = 32'h0000_0000;
   end

   // ****************************************
   // One transfer
   // ****************************************
   // Setup, then access until ready; commands carry their paired bit as issued.
   // Released address and data show the inverse, so a slave that keeps
   // sampling them after the transfer cannot see the old value by luck.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      PSEL_O    <= 1'b1;
      PENABLE_O <= 1'b0;
      PWRITE_O  <= w;
      PADDR_O   <= a;
      PWDATA_O  <= d;
      @(posedge SYS_CLK_I);
      PENABLE_O <= 1'b1;
      @(posedge SYS_CLK_I);
      // No wait-state count is assumed; only the bench timeout ends a hang.
      while (PREADY_I !== 1'b1)
      begin
         @(posedge SYS_CLK_I);
      end
      r = PRDATA_I;
      e = PSLVERR_I;
      PSEL_O    <= 1'b0;
      PENABLE_O <= 1'b0;
      PADDR_O   <= ~a;
      PWDATA_O  <= ~d;
      // One idle cycle keeps two transfers from driving in one time step.
      @(posedge SYS_CLK_I);
   endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Self-checking testbench of the parity and bit manipulation core.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import lfsrbm_pkg::*;

   // ****************************************
   // Signals
   // ****************************************
   logic             SYS_CLK_I;   // Core clock, 50 ns period.
   logic             SRST_I;      // Synchronous reset.
   logic             psel, penable, pwrite;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata;
   logic             pready, pslverr, cond_flag;
   int               num_errors;
   int               total_checks;
   int               cyc;
   logic [31:0]      seed;        // Random generator state.

   lfsrbm_core i_lfsrbm_core (.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .COND_FLAG_O(cond_flag));

   lfsrbm_apb_master i_lfsrbm_apb_master (.SYS_CLK_I(SYS_CLK_I), .PSEL_O(psel),
      .PENABLE_O(penable), .PWRITE_O(pwrite), .PADDR_O(paddr), .PWDATA_O(pwdata),
      .PRDATA_I(prdata), .PREADY_I(pready), .PSLVERR_I(pslverr));

   // ****************************************
   // Clock and timeout
   // ****************************************
   // The clock toggles every half period.
   initial
   begin
      SYS_CLK_I = 1'b0;
      forever #25 SYS_CLK_I = ~SYS_CLK_I;
   end

   // A hung handshake ends the run well above the expected 3500 cycles.
   initial cyc = 0;
   always @(posedge SYS_CLK_I)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         num_errors++;
         final_report();
      end
   end

   // ****************************************
   // Helpers
   // ****************************************
   // Shift register generator for repeatable random values.
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   // Reference fold of the masked state.
   function automatic logic par(input logic [39:0] s, input logic [39:0] m);
      return ^(s & m);
   endfunction

   // Compares and counts; a mismatch is reported at once.
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Register access with the expected error answer.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
      logic [31:0] r;
      logic        e;
      i_lfsrbm_apb_master.xfer(1'b1, a, d, r, e);
      check(e, ee);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r, input logic ee);
      logic e;
      i_lfsrbm_apb_master.xfer(1'b0, a, 32'h0000_0000, r, e);
      check(e, ee);
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin : main
      logic [39:0]      st, mk;
      logic [31:0]      dt, ds, r, t, cmd, lc;
      lfsrbm_flags_type fl;
      logic [2:0]       opc;
      logic [4:0]       idx;
      logic             pr, ee, res;
      num_errors = 0;
      total_checks = 0;
      seed = 32'h0000_003C;
      lc = 32'h0000_0000;
      SRST_I = 1'b1;
      repeat (20) @(posedge SYS_CLK_I);
      SRST_I <= 1'b0;
      @(posedge SYS_CLK_I);
      // Every register reads zero after reset.
      for (int k = 0; k < 8; k++)
      begin
         rd(8'(k * 4), r, 1'b0);
         check(r, 32'h0000_0000);
      end
      // Every code, both index ends, refused pairing and unmapped places.
      for (int i = 0; i < 64; i++)
      begin
         t = rnd();
         st = {t[7:0], rnd()};
         mk = {t[15:8], rnd()};
         // A mask disjoint from the state makes the feedback fold zero.
         if (i % 8 == 3 && i < 32)
            mk = ~st;
         opc = i[2:0];
         idx = (i < 16) ? (i[3] ? 5'h1F : 5'h00) : t[20:16];
         dt = (i % 3 == 0) ? (32'h0000_0001 << idx) : rnd();
         ds = rnd();
         fl = t[28:24];
         pr = (i % 5 == 4);
         ee = pr && (opc >= 3'h5);
         cmd = {19'h0, pr, 3'h0, idx, 1'b0, opc};
         wr(OFS_STATE_LO, st[31:0], 1'b0);
         wr(OFS_STATE_HI, {t[31:8], st[39:32]}, 1'b0);
         wr(OFS_MASK_LO, mk[31:0], 1'b0);
         wr(OFS_MASK_HI, {t[31:8], mk[39:32]}, 1'b0);
         wr(OFS_DATA, dt, 1'b0);
         wr(OFS_DEST, ds, 1'b0);
         wr(OFS_FLAGS, {27'h0, fl}, 1'b0);
         wr(OFS_CMD, cmd, ee);
         if (!ee)
         begin
            lc = cmd;
            case (opc)
               3'h1:
               begin
                  st = st << 1;
                  res = par(st, {8'h00, dt});
               end
               3'h2: res = par(st, {8'h00, dt});
               3'h3, 3'h4: res = par(st, mk) ^ fl.condition_flag;
               3'h5: dt[idx] = 1'b0;
               3'h6: dt[idx] = 1'b1;
               3'h7: dt[idx] = ~dt[idx];
               default: res = 1'b0;
            endcase
            if (opc >= 3'h1 && opc <= 3'h3)
            begin
               ds[15:0] = {15'h0000, res};
               fl.condition_flag = res;
            end
            if (opc == 3'h4)
               st = {st[38:0], res};
            if (opc >= 3'h5)
            begin
               fl.zero_flag = (opc == 3'h6) ? 1'b0 : (dt == 32'h0000_0000);
               fl.negative_flag = dt[31];
               fl.carry_flag = 1'b0;
               fl.ovf_flag = 1'b0;
            end
         end
         rd(8'h20, r, 1'b1);
         check(r, 32'h0000_0000);
         wr(8'h24, rnd(), 1'b1);
         rd(OFS_STATE_LO, r, 1'b0);
         check(r, st[31:0]);
         rd(OFS_STATE_HI, r, 1'b0);
         check(r, {24'h0, st[39:32]});
         rd(OFS_MASK_HI, r, 1'b0);
         check(r, {24'h0, mk[39:32]});
         rd(OFS_MASK_LO, r, 1'b0);
         check(r, mk[31:0]);
         rd(OFS_CMD, r, 1'b0);
         check(r, lc);
         rd(OFS_DATA, r, 1'b0);
         check(r, dt);
         rd(OFS_DEST, r, 1'b0);
         check(r, ds);
         rd(OFS_FLAGS, r, 1'b0);
         check(r[4:0], fl);
         check(cond_flag, fl.condition_flag);
      end
      final_report();
   end
endmodule
`default_nettype wire
